// File: verilog/bms_swap_regs.sv
// Top of the swap register bank: APB registers, swap sequencer and ROM header.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// [R01] 32-bit new-value register for swap
// [R02] 32-bit compare register checked against resource
// [R03] Two-bit selector picks one of four resources
// [R04] Done flag set when swap finishes
// [R05] A control write outside the swap cycle clears the done flag
// [R06] Control bits 30 to 2 read zero
// [R07] ROM header quadlet exported to the link
// [R08] Info and CRC length bytes, reset zero
// [R09] Software keeps CRC valid while link on
// [R10] Software programs header before link enable
// [R11] Atomic compare, swap, return old value
module bms_swap_regs #(
	parameter logic [31:0] RST_BUS_MGR_ID = 32'h0000_003f,
	parameter logic [31:0] RST_BANDWIDTH = 32'h0000_0000,
	parameter logic [31:0] RST_CHAN_HI = 32'hffff_ffff,
	parameter logic [31:0] RST_CHAN_LO = 32'hffff_ffff
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave port.
	input wire bms_pkg::bms_apb_req_type i_apb,
	output bms_pkg::bms_apb_rsp_type o_apb,
	// Link side.
	output bms_pkg::bms_rom_hdr_type o_rom_hdr,
	output logic o_swap_done
);
	import bms_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [DATA_W-1:0] new_reg; // Value to store; holds the old value after a swap.
	logic [DATA_W-1:0] new_next;
	logic [DATA_W-1:0] cmp_reg; // Value compared against the resource.
	logic [DATA_W-1:0] cmp_next;
	bms_res_type sel_reg; // Selected resource.
	bms_res_type sel_next;
	logic done_reg; // Done flag.
	logic done_next;
	bms_rom_hdr_type hdr_reg; // Configuration ROM first quadlet.
	bms_rom_hdr_type hdr_next;
	bms_state_type state_reg; // Sequencer state.
	bms_state_type state_next;
	logic wr; // Completing APB write strobe.
	logic addr_ok; // Address hits a mapped register.
	logic [DATA_W-1:0] rdata; // Read mux into the APB front end.
	logic [DATA_W-1:0] core_old; // Selected resource value.
	logic go; // Swap executes this cycle.
	logic wr_new; // Write to the new-value register.
	logic wr_cmp; // Write to the compare register.
	logic wr_ctrl; // Write to the control register.
	logic wr_hdr; // Write to the ROM header register.
	logic rd_ctrl_acc; // Access phase of a control read, seen by the checks.
	logic rd_hdr_acc; // Access phase of a header read, seen by the checks.

	////////////////////////////////////////////////////////////////////////////////
	// APB front end and decode.
	bms_apb_front u_front (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_req(i_apb),
		.o_rsp(o_apb),
		.i_rdata(rdata),
		.i_addr_ok(addr_ok),
		.o_wr(wr)
	);

	// Only the four words of this bank answer; everything else errors.
	always_comb begin
		addr_ok = 1'b1;
		rdata = RST_WORD;
		unique case (i_apb.paddr)
			OFF_SWAP_NEW: begin
				rdata = new_reg;
			end
			OFF_SWAP_CMP: begin
				rdata = cmp_reg;
			end
			OFF_SWAP_CTRL: begin
				// Reserved middle bits stay zero from the default above.
				rdata[DONE_BIT] = done_reg; // [R04]
				rdata[SEL_MSB:SEL_LSB] = sel_reg; // [R06]
			end
			OFF_ROM_HDR: begin
				rdata = hdr_reg; // [R07]
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	assign wr_new = wr && (i_apb.paddr == OFF_SWAP_NEW);
	assign wr_cmp = wr && (i_apb.paddr == OFF_SWAP_CMP);
	assign wr_ctrl = wr && (i_apb.paddr == OFF_SWAP_CTRL);
	assign wr_hdr = wr && (i_apb.paddr == OFF_ROM_HDR);

	////////////////////////////////////////////////////////////////////////////////
	// Swap sequencer.
	// A control write arms the swap; it runs in the next cycle so that the
	// selector and operands written so far are all settled.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (wr_ctrl) begin
					state_next = ST_SWAP; // [R11]
				end
			end
			ST_SWAP: begin
				// A control write landing in the swap cycle arms the next swap.
				state_next = wr_ctrl ? ST_SWAP : ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign go = (state_reg == ST_SWAP);

	bms_swap_core #(
		.RST_BUS_MGR_ID(RST_BUS_MGR_ID),
		.RST_BANDWIDTH(RST_BANDWIDTH),
		.RST_CHAN_HI(RST_CHAN_HI),
		.RST_CHAN_LO(RST_CHAN_LO)
	) u_core (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_go(go),
		.i_sel(sel_reg),
		.i_cmp(cmp_reg),
		.i_new(new_reg),
		.o_old(core_old)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Operand and control registers.
	// The returned old value wins over a software write in the swap cycle, so the
	// answer of a finished swap is never lost; software should not write then.
	always_comb begin
		new_next = new_reg;
		cmp_next = cmp_reg;
		sel_next = sel_reg;
		done_next = done_reg;
		if (wr_new) begin
			new_next = i_apb.pwdata; // [R01]
		end
		if (wr_cmp) begin
			cmp_next = i_apb.pwdata; // [R02]
		end
		if (wr_ctrl) begin
			// Only the selector takes write data; bit 31 and the rest are ignored.
			sel_next = bms_res_type'(i_apb.pwdata[SEL_MSB:SEL_LSB]); // [R03] [R06]
			done_next = 1'b0; // [R05]
		end
		if (go) begin
			new_next = core_old; // [R11]
			done_next = 1'b1; // [R04]
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			new_reg <= RST_WORD;
			cmp_reg <= RST_WORD;
			sel_reg <= RES_BUS_MGR_ID;
			done_reg <= RST_DONE;
		end else begin
			new_reg <= new_next;
			cmp_reg <= cmp_next;
			sel_reg <= sel_next;
			done_reg <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration ROM header.
	// The link reads this quadlet directly; software must keep it valid while the
	// link runs, since no checking is done here.
	always_comb begin
		hdr_next = hdr_reg;
		if (wr_hdr) begin
			hdr_next.info_length = i_apb.pwdata[INFO_LSB +: 8]; // [R08]
			hdr_next.crc_length = i_apb.pwdata[CRCLEN_LSB +: 8]; // [R08]
			hdr_next.rom_crc = i_apb.pwdata[CRC_LSB +: 16]; // [R09]
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hdr_reg <= '{info_length: RST_INFO_LEN, crc_length: RST_CRC_LEN,
				rom_crc: RST_ROM_CRC};
		end else begin
			hdr_reg <= hdr_next;
		end
	end

	assign o_rom_hdr = hdr_reg; // [R07]
	assign o_swap_done = done_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Read access phases; read data then shows the word as it stood at the setup edge.
	assign rd_ctrl_acc = o_apb.pready && !i_apb.pwrite && (i_apb.paddr == OFF_SWAP_CTRL);
	assign rd_hdr_acc = o_apb.pready && !i_apb.pwrite && (i_apb.paddr == OFF_ROM_HDR);

	// Control write in idle, which arms one swap cycle.
	sequence s_arm;
		wr_ctrl && (state_reg == ST_IDLE);
	endsequence

	sequence s_clear_then_set;
		!done_reg ##1 done_reg;
	endsequence

	// Swap cycle whose compare matches; no further swap is armed behind it.
	sequence s_hit;
		go && (core_old == cmp_reg) && !wr_ctrl;
	endsequence

	// Swap cycle whose compare fails; the resource must stay as it was.
	sequence s_miss;
		go && (core_old != cmp_reg) && !wr_ctrl;
	endsequence

	chk_new_write: assert property (wr_new && !go |=> new_reg == $past(i_apb.pwdata)) // [R01]
		else $error("new-value register did not take write data");

	chk_cmp_write: assert property (wr_cmp |=> cmp_reg == $past(i_apb.pwdata)) // [R02]
		else $error("compare register did not take write data");

	chk_sel_write: assert property (wr_ctrl // [R03]
		|=> sel_reg == $past(i_apb.pwdata[SEL_MSB:SEL_LSB]))
		else $error("selector did not take write data");

	chk_done_sets: assert property (s_arm |=> go ##1 done_reg) // [R04]
		else $error("done flag not set one cycle after swap");

	chk_done_clear: assert property (s_arm |=> s_clear_then_set) // [R05]
		else $error("control write did not clear done flag");

	chk_resv_zero: assert property (rd_ctrl_acc // [R06]
		|-> o_apb.prdata[RSV_MSB:RSV_LSB] == '0)
		else $error("reserved control bits read nonzero");

	chk_rom_export: assert property (wr_hdr |=> o_rom_hdr == $past(i_apb.pwdata)) // [R07]
		else $error("ROM header output does not follow write");

	chk_hdr_stable: assert property (!wr_hdr |=> $stable(o_rom_hdr)) // [R08]
		else $error("ROM header changed without a write");

	chk_swap_old: assert property (go |=> new_reg == $past(core_old)) // [R11]
		else $error("old resource value not returned");

	// The old value is only returned by a swap that a control write armed.
	chk_one_swap: assert property (go |-> $past(wr_ctrl)) // [R11]
		else $error("swap ran without a control write");

	// A match stores the new value into the selected resource.
	chk_swap_hit: assert property (s_hit |=> core_old == $past(new_reg)) // [R11]
		else $error("matching swap did not store the new value");

	// A failed compare leaves the selected resource alone.
	chk_swap_miss: assert property (s_miss |=> $stable(core_old)) // [R02]
		else $error("failed compare changed the resource");

	// Done stays up until software writes the control register.
	chk_done_holds: assert property (done_reg && !wr_ctrl |=> done_reg) // [R04]
		else $error("done flag dropped without a control write");

	// A control write outside the swap cycle always clears done.
	chk_done_drop: assert property (wr_ctrl && !go |=> !done_reg) // [R05]
		else $error("control write left done flag set");

	// Selector and compare value change only when software writes them.
	chk_sel_hold: assert property (!wr_ctrl |=> $stable(sel_reg)) // [R03]
		else $error("selector changed without a write");

	chk_cmp_hold: assert property (!wr_cmp |=> $stable(cmp_reg)) // [R02]
		else $error("compare register changed without a write");

	// Control reads show done and the selector as they stood at the setup edge.
	chk_ctrl_read: assert property (rd_ctrl_acc // [R04]
		|-> o_apb.prdata[DONE_BIT] == $past(done_reg))
		else $error("done flag read back wrong");

	chk_sel_read: assert property (rd_ctrl_acc // [R03]
		|-> o_apb.prdata[SEL_MSB:SEL_LSB] == $past(sel_reg))
		else $error("selector read back wrong");

	// Header reads return the same quadlet that the link sees.
	chk_hdr_read: assert property (rd_hdr_acc // [R07]
		|-> o_apb.prdata == $past(o_rom_hdr))
		else $error("header read differs from exported quadlet");

endmodule

// File: verilog/bms_pkg.sv
// Package with the map, field layout and types of the bus-management swap registers.
package bms_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the APB bus.
	localparam int ADDR_W = 12; // Width of the decoded APB address.
	localparam logic [ADDR_W-1:0] OFF_SWAP_NEW = 12'h00c; // New value / returned old value.
	localparam logic [ADDR_W-1:0] OFF_SWAP_CMP = 12'h010; // Compare value.
	localparam logic [ADDR_W-1:0] OFF_SWAP_CTRL = 12'h014; // Done flag and selector.
	localparam logic [ADDR_W-1:0] OFF_ROM_HDR = 12'h018; // First configuration ROM quadlet.

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values.
	localparam int DATA_W = 32; // Register and resource width.
	localparam int DONE_BIT = 31; // Done flag in the control register.
	localparam int SEL_LSB = 0; // Selector low bit.
	localparam int SEL_MSB = 1; // Selector high bit.
	localparam int RSV_LSB = 2; // Lowest reserved control bit.
	localparam int RSV_MSB = 30; // Highest reserved control bit.
	localparam int INFO_LSB = 24; // Info-length field low bit.
	localparam int CRCLEN_LSB = 16; // CRC-length field low bit.
	localparam int CRC_LSB = 0; // ROM CRC field low bit.
	localparam logic RST_DONE = 1'b1; // The done flag reads one after reset.
	localparam logic [7:0] RST_INFO_LEN = 8'h00; // Info-length reset value.
	localparam logic [7:0] RST_CRC_LEN = 8'h00; // CRC-length reset value.
	localparam logic [15:0] RST_ROM_CRC = 16'h0000; // CRC field reset value (left open).
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000; // Reset of data and compare.
	localparam int NUM_RES = 4; // Number of swap resources.

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	// Resource selector encodings.
	typedef enum logic [1:0] {
		RES_BUS_MGR_ID = 2'h0,
		RES_BANDWIDTH = 2'h1,
		RES_CHAN_HI = 2'h2,
		RES_CHAN_LO = 2'h3
	} bms_res_type;

	// Swap sequencer states.
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_SWAP = 1'b1
	} bms_state_type;

	// APB request from the master.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} bms_apb_req_type;

	// APB answer to the master.
	typedef struct packed {
		logic pready;
		logic [DATA_W-1:0] prdata;
		logic pslverr;
	} bms_apb_rsp_type;

	// Configuration ROM first quadlet.
	typedef struct packed {
		logic [7:0] info_length;
		logic [7:0] crc_length;
		logic [15:0] rom_crc;
	} bms_rom_hdr_type;

endpackage

// File: verilog/bms_apb_front.sv
// APB slave front end: registered ready, read data and error, plus write strobe.
`timescale 1ns/10ps
module bms_apb_front (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB bus.
	input wire bms_pkg::bms_apb_req_type i_req,
	output bms_pkg::bms_apb_rsp_type o_rsp,
	// Register file side.
	input wire logic [bms_pkg::DATA_W-1:0] i_rdata,
	input wire logic i_addr_ok,
	output logic o_wr
);
	import bms_pkg::*;

	bms_apb_rsp_type rsp_reg; // Registered answer.
	bms_apb_rsp_type rsp_next; // Its next value.

	// Ready rises in the cycle after setup, so every access phase lasts one cycle.
	// Read data is captured at the setup edge, which keeps prdata a flop output.
	always_comb begin
		rsp_next = rsp_reg;
		rsp_next.pready = i_req.psel & ~i_req.penable;
		if (i_req.psel && !i_req.penable) begin
			rsp_next.prdata = i_req.pwrite ? RST_WORD : i_rdata;
			rsp_next.pslverr = ~i_addr_ok;
		end else begin
			rsp_next.pslverr = 1'b0;
		end
	end

	// Register the answer.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
		end
	end

	// A write takes effect only at the completing edge, and never to an unmapped word.
	assign o_wr = i_req.psel & i_req.penable & rsp_reg.pready & i_req.pwrite & i_addr_ok;
	assign o_rsp = rsp_reg;

endmodule

// File: verilog/bms_swap_core.sv
// Four bus-management resources with an atomic compare-and-swap port.
`timescale 1ns/10ps
module bms_swap_core #(
	parameter logic [31:0] RST_BUS_MGR_ID = 32'h0000_003f,
	parameter logic [31:0] RST_BANDWIDTH = 32'h0000_0000,
	parameter logic [31:0] RST_CHAN_HI = 32'hffff_ffff,
	parameter logic [31:0] RST_CHAN_LO = 32'hffff_ffff
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Swap request.
	input wire logic i_go,
	input wire bms_pkg::bms_res_type i_sel,
	input wire logic [bms_pkg::DATA_W-1:0] i_cmp,
	input wire logic [bms_pkg::DATA_W-1:0] i_new,
	// Current value of the selected resource.
	output logic [bms_pkg::DATA_W-1:0] o_old
);
	import bms_pkg::*;

	localparam logic [NUM_RES*DATA_W-1:0] RST_ALL = {RST_CHAN_LO, RST_CHAN_HI,
		RST_BANDWIDTH, RST_BUS_MGR_ID};

	logic [DATA_W-1:0] res_reg [NUM_RES]; // Resource storage.
	logic [DATA_W-1:0] res_next [NUM_RES]; // Next values.

	// One entry per resource; only the selected one may change, and only on a match.
	for (genvar g = 0; g < NUM_RES; g++) begin : g_res
		always_comb begin
			res_next[g] = res_reg[g];
			if (i_go && (i_sel == bms_res_type'(g)) && (res_reg[g] == i_cmp)) begin
				res_next[g] = i_new;
			end
		end

		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				res_reg[g] <= RST_ALL[g*DATA_W +: DATA_W];
			end else begin
				res_reg[g] <= res_next[g];
			end
		end
	end

	// The old value is read in the same cycle as the swap, so the pair is atomic.
	assign o_old = res_reg[i_sel];

endmodule

// File: bench/bms_swap_regs_tb.sv
// Self-checking bench for the bus-management swap register bank.
`timescale 1ns/10ps
module bms_swap_regs_tb;
	import bms_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Resource reset values handed to the design; every expectation uses these.
	localparam logic [31:0] RV0 = 32'h0000_003f;
	localparam logic [31:0] RV1 = 32'h0000_0000;
	localparam logic [31:0] RV2 = 32'hffff_ffff;
	localparam logic [31:0] RV3 = 32'hffff_ffff;

	logic i_clk; // Bench clock, 20 ns period.
	logic i_rst_n; // Active-low reset.
	bms_apb_req_type req; // Bus request to the design.
	bms_apb_rsp_type rsp; // Bus answer from the design.
	bms_rom_hdr_type hdr; // Exported ROM quadlet.
	logic done; // Done flag pin.
	int n_mismatch; // Mismatches seen.
	int samples_checked; // Comparisons made.
	logic [31:0] rd; // Read data taken at the ready edge.
	logic err; // Error code taken at the ready edge.
	logic [31:0] rv [4]; // Reset values indexed by selector.

	bms_swap_regs #(
		.RST_BUS_MGR_ID(RV0),
		.RST_BANDWIDTH(RV1),
		.RST_CHAN_HI(RV2),
		.RST_CHAN_LO(RV3)
	) uut (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_apb(req),
		.o_apb(rsp),
		.o_rom_hdr(hdr),
		.o_swap_done(done)
	);

	// Free-running clock.
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one word and counts the outcome.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge i_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// A slave that never answers must not hang the run; nothing follows the verdict.
		if (rsp.pready !== 1'b1) begin
			n_mismatch++;
			$display("BAD t=%0t ready %h %h", $time, 32'h0, 32'h1);
			close_out();
		end else begin
			#1;
		end
	endtask

	// Reads one register and compares it.
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset state of registers and pins.
	task automatic t_reset();
		chk({31'h0, done}, 32'h1);
		chk(hdr, 32'h0);
		rchk(OFF_SWAP_CTRL, 32'h8000_0000);
		rchk(OFF_ROM_HDR, 32'h0);
		rchk(OFF_SWAP_NEW, 32'h0);
		rchk(OFF_SWAP_CMP, 32'h0);
	endtask

	// One compare-swap; reserved bits are written as ones and bit 31 as the selector's low bit.
	task automatic swap(input logic [1:0] s, input logic [31:0] nv, input logic [31:0] cv,
		input logic [31:0] old);
		apb(1'b1, OFF_SWAP_NEW, nv);
		apb(1'b1, OFF_SWAP_CMP, cv);
		rchk(OFF_SWAP_CMP, cv);
		apb(1'b1, OFF_SWAP_CTRL, {s[0], 29'h1fff_ffff, s});
		chk({31'h0, done}, 32'h0);
		@(posedge i_clk);
		#1;
		chk({31'h0, done}, 32'h1);
		rchk(OFF_SWAP_CTRL, {1'b1, 29'h0, s});
		rchk(OFF_SWAP_NEW, old);
	endtask

	// Hit, miss and hit again on every resource, proving the miss left it alone.
	task automatic t_swaps();
		for (int s = 0; s < 4; s++) begin
			swap(s[1:0], 32'h1234_0000 | s, rv[s], rv[s]);
			swap(s[1:0], 32'h5a5a_0000 | s, ~rv[s], 32'h1234_0000 | s);
			swap(s[1:0], 32'hc3c3_0000 | s, 32'h1234_0000 | s, 32'h1234_0000 | s);
		end
		// Resources stay separate: the first one still holds its own value.
		swap(2'h0, 32'h0, 32'h0, 32'hc3c3_0000);
	endtask

	// Header fields are writable and appear on the exported quadlet.
	// Software writes the whole quadlet at once, so the link never sees a half-written CRC.
	task automatic t_rom();
		apb(1'b1, OFF_ROM_HDR, 32'ha53c_9e71);
		chk(hdr, 32'ha53c_9e71);
		rchk(OFF_ROM_HDR, 32'ha53c_9e71);
		apb(1'b1, OFF_ROM_HDR, 32'h5ac3_618e);
		chk(hdr, 32'h5ac3_618e);
		rchk(OFF_ROM_HDR, 32'h5ac3_618e);
		chk({31'h0, err}, 32'h0);
	endtask

	// Unmapped places answer with an error, read zero and change nothing.
	task automatic t_unmapped();
		apb(1'b1, 12'h01c, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		rchk(12'h000, 32'h0);
		chk({31'h0, err}, 32'h1);
		rchk(OFF_ROM_HDR, 32'h5ac3_618e);
	endtask

	// A second reset in mid-run restores the defaults.
	task automatic t_rerst();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		#1;
		t_reset();
		swap(2'h1, 32'h7, RV1, RV1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rv = '{RV0, RV1, RV2, RV3};
		n_mismatch = 0;
		samples_checked = 0;
		req = '0;
		i_rst_n = 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		#1;
		t_reset();
		t_swaps();
		t_rom();
		t_unmapped();
		t_rerst();
		close_out();
	end
endmodule
